// File: rtl/tweep_map.svh
// constants of the three-wire eeprom port: array shape, opcodes, frame clocks, timing
// assumes inclusion by bare name from the package and the port module
`ifndef TWEEP_MAP_SVH
`define TWEEP_MAP_SVH
`define TWEEP_AW 7
`define TWEEP_DW 16
`define TWEEP_WORDS 128
`define TWEEP_OP_EXT 2'h0
`define TWEEP_OP_WRITE 2'h1
`define TWEEP_OP_READ 2'h2
`define TWEEP_OP_ERASE 2'h3
`define TWEEP_EXT_WDIS 2'h0
`define TWEEP_EXT_WALL 2'h1
`define TWEEP_EXT_EALL 2'h2
`define TWEEP_EXT_WEN 2'h3
`define TWEEP_N_OP 5'h02
`define TWEEP_N_EXT 5'h04
`define TWEEP_N_ADDR 5'h0A
`define TWEEP_N_DATA 5'h1A
`define TWEEP_N_MAX 5'h1F
`define TWEEP_ERASED 16'hFFFF
`define TWEEP_BIT_TOP 4'hF
`define TWEEP_PROG_TIME_MS 5
`define TWEEP_CLK_KHZ 50000
`define TWEEP_PROG_CYCLES (`TWEEP_PROG_TIME_MS * `TWEEP_CLK_KHZ)
`define TWEEP_TMR_W 18
`define TWEEP_SY_CS 0
`define TWEEP_SY_TGL 1
`define TWEEP_SY_STA 2
`define TWEEP_SY_RDA 3
`define TWEEP_SY_RDB 4
`define TWEEP_SY_N 5
`endif

// File: rtl/tweep_pkg.sv
// types of the three-wire eeprom port
// assumes tweep_map.svh is on the include path
`include "tweep_map.svh"
package tweep_pkg;
	typedef enum logic [2:0] {
		TW_IDLE = 3'h1,
		TW_PEND = 3'h2,
		TW_BUSY = 3'h4
	} tweep_state_t;
	typedef enum logic [2:0] {
		K_NONE = 3'h0,
		K_WEN = 3'h1,
		K_WDIS = 3'h2,
		K_WRITE = 3'h3,
		K_WALL = 3'h4,
		K_ERASE = 3'h5,
		K_EALL = 3'h6
	} tweep_kind_t;
endpackage : tweep_pkg

// File: rtl/tweep_port.sv
// command sequencer, array and self-timed programming of a 128x16 three-wire serial eeprom
// assumes a host drives CHIP_SELECT, SERIAL_CLOCK and SERIAL_DATA_IN; the data-out pin
// is resolved outside from SERIAL_DATA_OUT and SERIAL_DATA_OUT_EN_N
// How it works
// - sample input bits on serial clock rise
// - read output changes on serial clock rise
// - status after programming; float while select low
// - start, two opcode bits, address, msb first
// - skip leading zeros, first one starts
// - read gives dummy zero then word
// - read streaming increments address pointer
// - enable command sets write latch
// - write latch clear at power-up
// - read ignores write latch
// - enable/disable ignore trailing address bits
// - disable command clears write latch
// - write programs on select fall after 27
// - write and write-all erase first
// - write-all programs every word together
// - erase sets word to ones
// - erase-all sets every word to ones
// - busy low, commands refused, self ends
// - ready high when programming completes
// - write cancelled before 27th rise
// - erase cancelled before 11th rise
`timescale 1ns/1ps
`include "tweep_map.svh"
module tweep_port import tweep_pkg::*; #(
	parameter int unsigned PROG_CYCLES = `TWEEP_PROG_CYCLES
) (
	// system clock and control
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic CE,
	// serial link
	input wire logic CHIP_SELECT,
	input wire logic SERIAL_CLOCK,
	input wire logic SERIAL_DATA_IN,
	// serial data out pin
	output logic SERIAL_DATA_OUT,
	output logic SERIAL_DATA_OUT_EN_N
);

	// link domain; frame and read state cleared by select low, event words kept
	logic started_r;
	logic [4:0] n_r;
	logic [24:0] sh_r;
	logic [1:0] op_r;
	logic rd_act_r;
	logic rd_bit_r;
	logic [`TWEEP_AW-1:0] ptr_r;
	logic [3:0] bidx_r;
	logic [`TWEEP_DW-1:0] mem_r [0:`TWEEP_WORDS-1];
	logic [`TWEEP_DW-1:0] rd_word;
	logic fire;
	tweep_kind_t fire_kind;
	logic [`TWEEP_AW-1:0] fire_addr;
	logic evt_tgl_r = 1'b0;
	tweep_kind_t evt_kind_r;
	logic [`TWEEP_AW-1:0] evt_addr_r;
	logic [`TWEEP_DW-1:0] evt_data_r;

	// the array only changes on the clock that moves pending to busy, with select low and no read answered, so the link reads it directly
	assign rd_word = mem_r[ptr_r];

	always_ff @(posedge SERIAL_CLOCK or negedge CHIP_SELECT) begin
		if (!CHIP_SELECT) begin
			started_r <= 1'b0;
			n_r <= 5'h00;
			sh_r <= 25'h0000000;
			op_r <= 2'h0;
		end else if (!started_r) begin
			if (SERIAL_DATA_IN) begin
				started_r <= 1'b1;
				n_r <= 5'h01;
			end
		end else begin
			sh_r <= {sh_r[23:0], SERIAL_DATA_IN};
			if (n_r != `TWEEP_N_MAX) begin
				n_r <= n_r + 5'h01;
			end
			if (n_r == `TWEEP_N_OP) begin
				op_r <= {sh_r[0], SERIAL_DATA_IN};
			end
		end
	end

	// read path never looks at the write latch
	always_ff @(posedge SERIAL_CLOCK or negedge CHIP_SELECT) begin
		if (!CHIP_SELECT) begin
			rd_act_r <= 1'b0;
			rd_bit_r <= 1'b0;
			ptr_r <= 7'h00;
			bidx_r <= `TWEEP_BIT_TOP;
		end else if (started_r && n_r == `TWEEP_N_ADDR && op_r == `TWEEP_OP_READ) begin
			rd_act_r <= 1'b1;
			rd_bit_r <= 1'b0;
			ptr_r <= {sh_r[5:0], SERIAL_DATA_IN};
			bidx_r <= `TWEEP_BIT_TOP;
		end else if (rd_act_r) begin
			rd_bit_r <= rd_word[bidx_r];
			if (bidx_r == 4'h0) begin
				ptr_r <= ptr_r + 7'h01;
				bidx_r <= `TWEEP_BIT_TOP;
			end else begin
				bidx_r <= bidx_r - 4'h1;
			end
		end
	end

	// a command fires only on the exact clock that completes it; select low before that abandons it
	always_comb begin
		fire = 1'b0;
		fire_kind = K_NONE;
		fire_addr = 7'h00;
		if (started_r && op_r == `TWEEP_OP_EXT && n_r == `TWEEP_N_EXT) begin
			if ({sh_r[0], SERIAL_DATA_IN} == `TWEEP_EXT_WEN) begin
				fire = 1'b1;
				fire_kind = K_WEN;
			end else if ({sh_r[0], SERIAL_DATA_IN} == `TWEEP_EXT_WDIS) begin
				fire = 1'b1;
				fire_kind = K_WDIS;
			end
		end else if (started_r && n_r == `TWEEP_N_ADDR) begin
			if (op_r == `TWEEP_OP_ERASE) begin
				fire = 1'b1;
				fire_kind = K_ERASE;
				fire_addr = {sh_r[5:0], SERIAL_DATA_IN};
			end else if (op_r == `TWEEP_OP_EXT && sh_r[6:5] == `TWEEP_EXT_EALL) begin
				fire = 1'b1;
				fire_kind = K_EALL;
			end
		end else if (started_r && n_r == `TWEEP_N_DATA) begin
			if (op_r == `TWEEP_OP_WRITE) begin
				fire = 1'b1;
				fire_kind = K_WRITE;
				fire_addr = sh_r[21:15];
			end else if (op_r == `TWEEP_OP_EXT && sh_r[22:21] == `TWEEP_EXT_WALL) begin
				fire = 1'b1;
				fire_kind = K_WALL;
			end
		end
	end

	// event words are held until the next command fires, long after the toggle is seen
	always_ff @(posedge SERIAL_CLOCK) begin
		if (fire) begin
			evt_tgl_r <= ~evt_tgl_r;
			evt_kind_r <= fire_kind;
			evt_addr_r <= fire_addr;
			evt_data_r <= {sh_r[14:0], SERIAL_DATA_IN};
		end
	end

	// crossings into the system clock: three flops, a change counts when two agree
	wire [`TWEEP_SY_N-1:0] src;
	wire [`TWEEP_SY_N-1:0] stab;
	assign src = {rd_bit_r, rd_act_r, started_r, evt_tgl_r, CHIP_SELECT};

	for (genvar i = 0; i < `TWEEP_SY_N; i++) begin : g_sync
		logic s1_r;
		logic s2_r;
		logic s3_r;
		logic st_r;
		always_ff @(posedge CLK) begin
			if (!RSTN) begin
				s1_r <= 1'b0;
				s2_r <= 1'b0;
				s3_r <= 1'b0;
				st_r <= 1'b0;
			end else if (CE) begin
				s1_r <= src[i];
				s2_r <= s1_r;
				s3_r <= s2_r;
				if (s2_r == s3_r) begin
					st_r <= s3_r;
				end
			end
		end
		assign stab[i] = st_r;
	end

	// system domain
	tweep_state_t state_r;
	logic ack_r;
	logic sta_prev_r;
	logic wel_r;
	logic stat_en_r;
	tweep_kind_t pkind_r;
	logic [`TWEEP_AW-1:0] paddr_r;
	logic [`TWEEP_DW-1:0] pdata_r;
	logic [`TWEEP_TMR_W-1:0] tmr_r;
	logic evt;
	logic is_prog;
	logic go;
	logic all_words;
	logic [`TWEEP_DW-1:0] pval;
	logic cs_hi;

	assign cs_hi = stab[`TWEEP_SY_CS];
	assign evt = CE && (stab[`TWEEP_SY_TGL] != ack_r);
	assign is_prog = (evt_kind_r == K_WRITE) || (evt_kind_r == K_WALL) ||
		(evt_kind_r == K_ERASE) || (evt_kind_r == K_EALL);
	assign go = CE && (state_r == TW_PEND) && !cs_hi;
	assign all_words = (pkind_r == K_WALL) || (pkind_r == K_EALL);
	assign pval = ((pkind_r == K_ERASE) || (pkind_r == K_EALL)) ? `TWEEP_ERASED : pdata_r;

	// reset takes the synced toggle, itself cleared by reset, as reference, so a link toggle left high shows as one stale event
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			ack_r <= stab[`TWEEP_SY_TGL];
			sta_prev_r <= 1'b0;
		end else if (CE) begin
			ack_r <= stab[`TWEEP_SY_TGL];
			sta_prev_r <= stab[`TWEEP_SY_STA];
		end
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			state_r <= TW_IDLE;
		end else if (CE) begin
			unique case (state_r)
				TW_IDLE: begin
					if (evt && is_prog && wel_r) begin
						state_r <= TW_PEND;
					end
				end
				TW_PEND: begin
					// select already low counts too, so a late-seen toggle still starts
					if (!cs_hi) begin
						state_r <= TW_BUSY;
					end
				end
				TW_BUSY: begin
					if (tmr_r == `TWEEP_TMR_W'(0)) begin
						state_r <= TW_IDLE;
					end
				end
			endcase
		end
	end

	// events while pending or busy are dropped
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			wel_r <= 1'b0;
		end else if (evt && state_r == TW_IDLE) begin
			if (evt_kind_r == K_WEN) begin
				wel_r <= 1'b1;
			end else if (evt_kind_r == K_WDIS) begin
				wel_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			pkind_r <= K_NONE;
			paddr_r <= 7'h00;
			pdata_r <= 16'h0000;
		end else if (evt && state_r == TW_IDLE && is_prog) begin
			pkind_r <= evt_kind_r;
			paddr_r <= evt_addr_r;
			pdata_r <= evt_data_r;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			tmr_r <= `TWEEP_TMR_W'(0);
		end else if (go) begin
			tmr_r <= `TWEEP_TMR_W'(PROG_CYCLES - 1);
		end else if (CE && state_r == TW_BUSY && tmr_r != `TWEEP_TMR_W'(0)) begin
			tmr_r <= tmr_r - `TWEEP_TMR_W'(1);
		end
	end

	// whole-word overwrite is the built-in erase before write
	for (genvar w = 0; w < `TWEEP_WORDS; w++) begin : g_cell
		always_ff @(posedge CLK) begin
			if (go && (all_words || paddr_r == `TWEEP_AW'(w))) begin
				mem_r[w] <= pval;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			stat_en_r <= 1'b0;
		end else if (go) begin
			stat_en_r <= 1'b1;
		end else if (CE && state_r != TW_BUSY && stab[`TWEEP_SY_STA] && !sta_prev_r) begin
			stat_en_r <= 1'b0;
		end
	end

	// pin flops; the crossing adds up to five system clocks, about 100 ns, to each read bit
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			SERIAL_DATA_OUT <= 1'b0;
			SERIAL_DATA_OUT_EN_N <= 1'b1;
		end else if (CE) begin
			if (!cs_hi) begin
				SERIAL_DATA_OUT <= 1'b0;
				SERIAL_DATA_OUT_EN_N <= 1'b1;
			end else if (stat_en_r) begin
				SERIAL_DATA_OUT <= (state_r != TW_BUSY);
				SERIAL_DATA_OUT_EN_N <= 1'b0;
			end else if (stab[`TWEEP_SY_RDA]) begin
				SERIAL_DATA_OUT <= stab[`TWEEP_SY_RDB];
				SERIAL_DATA_OUT_EN_N <= 1'b0;
			end else begin
				SERIAL_DATA_OUT <= 1'b0;
				SERIAL_DATA_OUT_EN_N <= 1'b1;
			end
		end
	end

	// checks
	chk_wel_set: assert property (@(posedge CLK) disable iff (!RSTN)
		(evt && state_r == TW_IDLE && evt_kind_r == K_WEN) |=> wel_r)
		else $error("enable command did not set write latch");

	chk_wel_clear: assert property (@(posedge CLK) disable iff (!RSTN)
		(evt && state_r == TW_IDLE && evt_kind_r == K_WDIS) |=> !wel_r)
		else $error("disable command did not clear write latch");

	chk_locked_prog: assert property (@(posedge CLK) disable iff (!RSTN)
		(evt && state_r == TW_IDLE && is_prog && !wel_r) |=> (state_r == TW_IDLE)[*2])
		else $error("programming started with write latch clear");

	chk_fall_start: assert property (@(posedge CLK) disable iff (!RSTN)
		go |=> (state_r == TW_BUSY) && (tmr_r == `TWEEP_TMR_W'(PROG_CYCLES - 1)))
		else $error("select fall did not start timed cycle");

	chk_self_end: assert property (@(posedge CLK) disable iff (!RSTN)
		(CE && state_r == TW_BUSY && tmr_r == `TWEEP_TMR_W'(0)) |=> state_r == TW_IDLE)
		else $error("programming cycle did not end on its own");

	chk_busy_low: assert property (@(posedge CLK) disable iff (!RSTN)
		(CE && state_r == TW_BUSY && stat_en_r && cs_hi) |=> (!SERIAL_DATA_OUT && !SERIAL_DATA_OUT_EN_N))
		else $error("busy not shown as driven low");

	chk_ready_high: assert property (@(posedge CLK) disable iff (!RSTN)
		(CE && state_r == TW_IDLE && stat_en_r && cs_hi) |=> (SERIAL_DATA_OUT && !SERIAL_DATA_OUT_EN_N))
		else $error("ready not shown as driven high");

	chk_float_low: assert property (@(posedge CLK) disable iff (!RSTN)
		(CE && !cs_hi) |=> SERIAL_DATA_OUT_EN_N)
		else $error("output driven while select low");

	chk_erase_ones: assert property (@(posedge CLK) disable iff (!RSTN)
		(go && pkind_r == K_ERASE) |=> mem_r[$past(paddr_r)] == `TWEEP_ERASED)
		else $error("erased word not all ones");

	chk_write_word: assert property (@(posedge CLK) disable iff (!RSTN)
		(go && pkind_r == K_WRITE) |=> mem_r[$past(paddr_r)] == $past(pdata_r))
		else $error("written word does not hold data");

	chk_start_bit: assert property (@(posedge SERIAL_CLOCK) disable iff (!CHIP_SELECT)
		(!started_r && SERIAL_DATA_IN) |=> (started_r && n_r == 5'h01))
		else $error("start bit not taken");

	chk_dummy_zero: assert property (@(posedge SERIAL_CLOCK) disable iff (!CHIP_SELECT)
		(started_r && n_r == `TWEEP_N_ADDR && op_r == `TWEEP_OP_READ) |=> (rd_act_r && !rd_bit_r))
		else $error("read did not open with dummy zero");

	chk_stream_next: assert property (@(posedge SERIAL_CLOCK) disable iff (!CHIP_SELECT)
		(rd_act_r && bidx_r == 4'h0) |=> (ptr_r == $past(ptr_r) + 7'h01) && (bidx_r == `TWEEP_BIT_TOP))
		else $error("read pointer did not advance");

	cov_write: cover property (@(posedge CLK) disable iff (!RSTN) go && pkind_r == K_WRITE);
	cov_erase_all: cover property (@(posedge CLK) disable iff (!RSTN) go && pkind_r == K_EALL);
	cov_enable: cover property (@(posedge CLK) disable iff (!RSTN) evt && evt_kind_r == K_WEN);
	cov_stream: cover property (@(posedge SERIAL_CLOCK) disable iff (!CHIP_SELECT) rd_act_r && bidx_r == 4'h0);

endmodule : tweep_port

// File: verification/tweep_host.sv
// host model: drives select, serial clock and data in, resolves the data-out wire
// assumes each task starts on a falling edge of the 20 ns system clock
`timescale 1ns/1ps
module tweep_host (
	// data-out pin from the device
	input wire logic dout,
	input wire logic doen_n,
	// serial link to the device
	output logic cs,
	output logic sclk,
	output logic sdin
);
	logic last = 1'b0;
	logic pin;
	// enable level seen at each sample, so a float is never mistaken for a driven bit
	logic [63:0] drv;
	// a released wire shows the inverse of its last level, so a float never passes as data
	assign pin = doen_n ? ~last : dout;
	always @(dout or doen_n) begin
		if (!doen_n) begin
			last = dout;
		end
	end
	initial begin
		cs = 1'b0;
		sclk = 1'b0;
		sdin = 1'b0;
	end
	// 80 ns per phase so each link event crosses inside the frame; clock idles low between frames
	task shift(input int n, input logic [63:0] v, output logic [63:0] r);
		r = '0;
		drv = '0;
		cs = 1'b1;
		for (int i = n - 1; i >= 0; i--) begin
			sdin = v[i];
			#80;
			r = {r[62:0], pin};
			drv = {drv[62:0], doen_n};
			sclk = 1'b1;
			#80;
			sclk = 1'b0;
		end
		sdin = 1'b0;
	endtask : shift
	task drop();
		cs = 1'b0;
		#200;
	endtask : drop
	task raise();
		cs = 1'b1;
		#100;
	endtask : raise
endmodule : tweep_host

// File: verification/tb_three_wire_serial_eeprom_port.sv
// testbench of the three-wire eeprom port against the host model
// assumes tweep_port and tweep_host are compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_three_wire_serial_eeprom_port;
	localparam int unsigned PROGC = 400;
	logic clk, rstn, cs, sclk, sdin, sdo, sdo_en_n;
	int errors = 0;
	int checks = 0;
	int cyc = 0;
	logic [63:0] r;
	tweep_port #(.PROG_CYCLES(PROGC)) dut (.CLK(clk), .RSTN(rstn), .CE(1'b1), .CHIP_SELECT(cs),
		.SERIAL_CLOCK(sclk), .SERIAL_DATA_IN(sdin), .SERIAL_DATA_OUT(sdo), .SERIAL_DATA_OUT_EN_N(sdo_en_n));
	tweep_host host (.dout(sdo), .doen_n(sdo_en_n), .cs(cs), .sclk(sclk), .sdin(sdin));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ceiling well above the roughly 6500 cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			errors++;
			print_verdict();
		end
	end
	task print_verdict();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict
	function logic [63:0] cmd(input logic [1:0] op, input logic [7:0] a);
		return {53'h0, 1'b1, op, a};
	endfunction : cmd
	function logic [63:0] wr(input logic [1:0] op, input logic [6:0] a, input logic [15:0] d);
		return (cmd(op, {1'b0, a}) << 16) | {48'h0, d};
	endfunction : wr
	task send(input int n, input logic [63:0] v);
		host.shift(n, v, r);
		host.drop();
	endtask : send
	// samples lag one clock: the last 16*w+1 samples are the dummy bit and the words
	task rd(input logic [6:0] a, input int w, input int z, input logic [31:0] e);
		logic [63:0] c;
		c = cmd(2'h2, {1'b0, a}) << (1 + 16 * w);
		send(12 + 16 * w + z, c);
		`CHK({host.drv[16 * w], r[16 * w]}, 2'b00)
		`CHK(r[15:0], e[15:0])
		if (w == 2) begin
			`CHK(r[31:16], e[31:16])
		end
	endtask : rd
	task prog(input int n, input logic [63:0] v);
		int k;
		send(n, v);
		host.raise();
		`CHK({sdo_en_n, host.pin}, 2'b00)
		k = 0;
		while (host.pin !== 1'b1 && k < 500) begin
			@(negedge clk);
			k++;
		end
		`CHK({sdo_en_n, host.pin, k > 360, k < 400}, 4'hF >> 1)
		host.drop();
		`CHK(sdo_en_n, 1'b1)
	endtask : prog
	task noprog(input int n, input logic [63:0] v);
		send(n, v);
		host.raise();
		`CHK(sdo_en_n, 1'b1)
		host.drop();
	endtask : noprog
	task t_nolatch();
		noprog(27, wr(2'h1, 7'h04, 16'h0F0F));
	endtask : t_nolatch
	task t_erase_all();
		send(11, cmd(2'h0, 8'hEA));
		prog(11, cmd(2'h0, 8'h80));
		rd(7'h7E, 2, 5, 32'hFFFFFFFF);
	endtask : t_erase_all
	task t_write();
		prog(27, wr(2'h1, 7'h05, 16'hA5A5));
		rd(7'h05, 1, 0, 32'hA5A5);
		prog(27, wr(2'h0, 7'h40, 16'h1234));
		rd(7'h7F, 2, 0, 32'h12341234);
		rd(7'h05, 1, 0, 32'h1234);
		prog(11, cmd(2'h3, 8'h03));
		rd(7'h02, 2, 0, 32'h1234FFFF);
	endtask : t_write
	task t_cancel();
		noprog(26, wr(2'h1, 7'h04, 16'h0000) >> 1);
		noprog(10, cmd(2'h3, 8'h04) >> 1);
		rd(7'h04, 1, 0, 32'h1234);
	endtask : t_cancel
	task t_busy();
		send(27, wr(2'h1, 7'h06, 16'h5A5A));
		send(11, cmd(2'h3, 8'h06));
		repeat (500) @(negedge clk);
		rd(7'h06, 1, 0, 32'h5A5A);
	endtask : t_busy
	task t_disable();
		send(11, cmd(2'h0, 8'h15));
		noprog(27, wr(2'h1, 7'h04, 16'h0000));
		noprog(11, cmd(2'h0, 8'h80));
		rd(7'h04, 1, 0, 32'h1234);
	endtask : t_disable
	initial begin
		rstn = 1'b0;
		repeat (20) @(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
		`CHK(sdo_en_n, 1'b1)
		t_nolatch();
		t_erase_all();
		t_write();
		t_cancel();
		t_busy();
		t_disable();
		print_verdict();
	end
endmodule : tb_three_wire_serial_eeprom_port
